// ---- logic/asr_pkg.sv ----
// Shared constants and types of the asynchronous serial receiver
package asr_pkg;

  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  localparam logic [2:0] REG_CTRL   = 3'h0;
  localparam logic [2:0] REG_DIV_LO = 3'h1;
  localparam logic [2:0] REG_DIV_HI = 3'h2;
  localparam logic [2:0] REG_STATUS = 3'h3;
  localparam logic [2:0] REG_DATA   = 3'h4;
  localparam logic [2:0] REG_IRQ    = 3'h5;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DIV_RST  = 8'h00;
  localparam logic [7:0] IRQ_RST  = 8'h00;

  // Oversampling accumulator steps per clock, per rate mode
  localparam logic [4:0] STEP_DIV64 = 5'h01;
  localparam logic [4:0] STEP_DIV16 = 5'h04;
  localparam logic [4:0] STEP_DIV4  = 5'h10;

  localparam logic [3:0] TICK_SMP_A = 4'h7;
  localparam logic [3:0] TICK_SMP_B = 4'h8;
  localparam logic [3:0] TICK_SMP_C = 4'h9;
  localparam logic [3:0] TICK_LAST  = 4'hf;
  localparam logic [3:0] BITS_8     = 4'h7;
  localparam logic [3:0] BITS_9     = 4'h8;

  localparam int FIFO_DEPTH = 16;

  typedef struct packed {
    logic spare;
    logic high_speed_rate_select;
    logic wide_divisor_select;
    logic address_filter_enable;
    logic continuous_rx_enable;
    logic nine_bit_rx_enable;
    logic clocked_mode_select;
    logic serial_port_enable;
  } asr_ctrl_t;

  typedef struct packed {
    logic       global_irq_enable;
    logic       peripheral_irq_enable;
    logic [3:0] spare;
    logic       rx_irq_priority;
    logic       rx_irq_enable;
  } asr_irqc_t;

  typedef struct packed {
    logic       ferr;
    logic       ninth;
    logic [7:0] data;
  } asr_word_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [2:0]  addr;
    logic [7:0]  wdata;
  } asr_bus_t;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} asr_rx_e;

  typedef struct packed {
    logic [2:0]  sync;
    logic        line;
    logic        line_prev;
    asr_ctrl_t   ctrl;
    logic [7:0]  div_lo;
    logic [7:0]  div_hi;
    asr_irqc_t   irqc;
    logic [18:0] acc;
    asr_rx_e     st;
    logic [3:0]  tick;
    logic [3:0]  nbit;
    logic [1:0]  smp;
    logic [8:0]  shift;
    logic        ovr;
    logic [7:0]  rdata;
    logic        irq_hi;
    logic        irq_lo;
  } asr_state_t;

endpackage

// ---- logic/asr_rx.sv ----
// Asynchronous serial receiver with receive FIFO and register port
// Contract
// - The receive pin feeds a recovery stage sampling at sixteen ticks per bit.
// - The shift register advances once per bit, on the system clock, from recovered samples.
// - The bit rate comes from a 16-bit divisor in two byte registers, scaled by the two rate selects; the code ignores div_hi while wide_divisor_select is 0.
// - Reception runs only while clocked mode is off and the port is enabled.
// - Nine data bits are taken per character in nine-bit mode, eight otherwise.
// - Characters are taken only while continuous receive is on; software sets it last.
// - A complete character raises the complete flag; an interrupt follows only if enabled.
// - The status register shows the ninth bit in nine-bit mode and the errors; read it first.
// - Reading the data register returns the low eight data bits.
// - Clearing continuous receive clears a latched error.
// - The interrupt goes out only while global and peripheral enables (bits 7 and 6) are set.
// - The interrupt goes to the high or low level by the priority setting.
// - With address filtering in nine-bit mode characters are filtered; once off, all enter.
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/100ps

module asr_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,       // System clock
  input  wire logic             rst_n,     // Synchronous reset
  input  wire logic             ce,        // Clock enable
  input  wire logic             in_valid,  // Write request
  output logic                  in_ready,  // Room for a word
  input  wire logic [WIDTH-1:0] in_data,   // Word written
  output logic                  out_valid, // Word available
  input  wire logic             out_ready, // Pop head word
  output logic [WIDTH-1:0]      out_data   // Head word
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wp;
    logic [PW-1:0]               rp;
    logic [CW-1:0]               cnt;
  } fifo_state_t;

  fifo_state_t f_q;
  fifo_state_t f_d;
  logic        push;
  logic        pop;

  assign in_ready  = (f_q.cnt != CW'(DEPTH));
  assign out_valid = (f_q.cnt != '0);
  assign out_data  = f_q.mem[f_q.rp];
  assign push      = in_valid & in_ready;
  assign pop       = out_ready & out_valid;

  always_comb begin
    f_d = f_q;
    if (push) begin
      f_d.mem[f_q.wp] = in_data;
      f_d.wp = (f_q.wp == PW'(DEPTH - 1)) ? '0 : f_q.wp + 1'b1;
    end
    if (pop) begin
      f_d.rp = (f_q.rp == PW'(DEPTH - 1)) ? '0 : f_q.rp + 1'b1;
    end
    if (push && !pop) begin
      f_d.cnt = f_q.cnt + 1'b1;
    end else if (pop && !push) begin
      f_d.cnt = f_q.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      f_q <= '0;
    end else if (ce) begin
      f_q <= f_d;
    end
  end

endmodule

module asr_rx #(
  parameter int DEPTH = asr_pkg::FIFO_DEPTH
) (
  input  wire logic             clk,           // System clock, 100 MHz
  input  wire logic             rst_n,         // Synchronous reset, active low
  input  wire logic             ce,            // Clock enable, freezes all state when low
  input  wire logic             serial_in_pin, // Receive line, idle high
  input  wire asr_pkg::asr_bus_t bus,          // Register request
  output logic [7:0]            rdata,         // Read data, cycle after the read
  output logic                  irq_high,      // High priority receive request
  output logic                  irq_low,       // Low priority receive request
  output logic                  rx_complete_flag // Character waiting in buffer
);

  asr_pkg::asr_state_t s_q;
  asr_pkg::asr_state_t s_d;
  asr_pkg::asr_word_t  push_word;
  asr_pkg::asr_word_t  head;
  logic                push_v;
  logic                fifo_ready;
  logic                fifo_valid;
  logic                pop;

  logic                active;
  logic [15:0]         divisor;
  logic [18:0]         limit;
  logic [4:0]          step;
  logic [18:0]         acc_next;
  logic                os_tick;
  logic                bitv;
  logic                keep;
  logic [7:0]          data_b;
  logic                ninth_b;
  logic                req;

  asr_fifo #(
    .WIDTH ($bits(asr_pkg::asr_word_t)),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .ce        (ce),
    .in_valid  (push_v),
    .in_ready  (fifo_ready),
    .in_data   (push_word),
    .out_valid (fifo_valid),
    .out_ready (pop),
    .out_data  (head)
  );

  // Port runs only in asynchronous mode with the port and reception on
  assign active = s_q.ctrl.serial_port_enable & ~s_q.ctrl.clocked_mode_select
                & s_q.ctrl.continuous_rx_enable;

  // Divisor and rate scaling
  assign divisor = s_q.ctrl.wide_divisor_select ? {s_q.div_hi, s_q.div_lo}
                                                : {8'h00, s_q.div_lo};
  assign limit   = {1'b0, divisor, 2'b00} + 19'h00004;

  always_comb begin
    case ({s_q.ctrl.wide_divisor_select, s_q.ctrl.high_speed_rate_select})
      2'b00:   step = asr_pkg::STEP_DIV64;
      2'b11:   step = asr_pkg::STEP_DIV4;
      default: step = asr_pkg::STEP_DIV16;
    endcase
  end

  // Sixteen oversampling ticks per bit
  assign acc_next = s_q.acc + {14'h0000, step};
  assign os_tick  = (s_q.st != asr_pkg::RX_IDLE) && (acc_next >= limit);

  // Majority of the three centre samples
  assign bitv = (s_q.smp[1] & s_q.smp[0]) | (s_q.smp[1] & s_q.line)
              | (s_q.smp[0] & s_q.line);

  // Eight-bit characters sit one place higher in the shifter
  assign data_b  = s_q.ctrl.nine_bit_rx_enable ? s_q.shift[7:0] : s_q.shift[8:1];
  assign ninth_b = s_q.ctrl.nine_bit_rx_enable & s_q.shift[8];
  assign keep    = ~(s_q.ctrl.address_filter_enable & s_q.ctrl.nine_bit_rx_enable)
                 | ninth_b;

  assign pop = bus.rd && (bus.addr == asr_pkg::REG_DATA) && fifo_valid;
  assign req = fifo_valid & s_q.irqc.rx_irq_enable
             & s_q.irqc.global_irq_enable & s_q.irqc.peripheral_irq_enable;

  always_comb begin
    s_d       = s_q;
    push_v    = 1'b0;
    push_word = '0;

    // Pin synchroniser; a level counts once the last two stages agree
    s_d.sync = {s_q.sync[1:0], serial_in_pin};
    if (s_q.sync[1] == s_q.sync[2]) begin
      s_d.line = s_q.sync[2];
    end
    s_d.line_prev = s_q.line;

    if (os_tick) begin
      s_d.acc  = acc_next - limit;
      s_d.tick = s_q.tick + 1'b1;
    end else if (s_q.st != asr_pkg::RX_IDLE) begin
      s_d.acc = acc_next;
    end

    case (s_q.st)
      asr_pkg::RX_IDLE: begin
        if (active && !s_q.ovr && s_q.line_prev && !s_q.line) begin
          s_d.st   = asr_pkg::RX_START;
          s_d.acc  = '0;
          s_d.tick = '0;
        end
      end
      asr_pkg::RX_START: begin
        if (os_tick && s_q.tick == asr_pkg::TICK_SMP_C && bitv) begin
          s_d.st = asr_pkg::RX_IDLE;
        end else if (os_tick && s_q.tick == asr_pkg::TICK_LAST) begin
          s_d.st   = asr_pkg::RX_DATA;
          s_d.nbit = '0;
        end
      end
      asr_pkg::RX_DATA: begin
        if (os_tick && s_q.tick == asr_pkg::TICK_SMP_C) begin
          s_d.shift = {bitv, s_q.shift[8:1]};
        end
        if (os_tick && s_q.tick == asr_pkg::TICK_LAST) begin
          if (s_q.nbit == (s_q.ctrl.nine_bit_rx_enable ? asr_pkg::BITS_9
                                                       : asr_pkg::BITS_8)) begin
            s_d.st = asr_pkg::RX_STOP;
          end else begin
            s_d.nbit = s_q.nbit + 1'b1;
          end
        end
      end
      asr_pkg::RX_STOP: begin
        if (os_tick && s_q.tick == asr_pkg::TICK_SMP_C) begin
          s_d.st = asr_pkg::RX_IDLE;
          if (keep) begin
            if (fifo_ready) begin
              push_v          = 1'b1;
              push_word.ferr  = ~bitv;
              push_word.ninth = ninth_b;
              push_word.data  = data_b;
            end else begin
              s_d.ovr = 1'b1;
            end
          end
        end
      end
      default: begin
        s_d.st = asr_pkg::RX_IDLE;
      end
    endcase

    if (os_tick && (s_q.tick == asr_pkg::TICK_SMP_A || s_q.tick == asr_pkg::TICK_SMP_B)) begin
      s_d.smp = {s_q.smp[0], s_q.line};
    end

    if (!active) begin
      s_d.st = asr_pkg::RX_IDLE;
    end
    if (!s_q.ctrl.continuous_rx_enable) begin
      s_d.ovr = 1'b0;
    end

    // Register reads
    s_d.rdata = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        asr_pkg::REG_CTRL:   s_d.rdata = s_q.ctrl;
        asr_pkg::REG_DIV_LO: s_d.rdata = s_q.div_lo;
        asr_pkg::REG_DIV_HI: s_d.rdata = s_q.div_hi;
        asr_pkg::REG_STATUS: s_d.rdata = {3'b000, s_q.st != asr_pkg::RX_IDLE, fifo_valid, s_q.ovr,
                                          fifo_valid & head.ferr,
                                          fifo_valid & head.ninth & s_q.ctrl.nine_bit_rx_enable};
        asr_pkg::REG_DATA:   s_d.rdata = fifo_valid ? head.data : 8'h00;
        asr_pkg::REG_IRQ:    s_d.rdata = s_q.irqc;
        default:             s_d.rdata = 8'h00;
      endcase
    end

    // Register writes
    if (bus.wr) begin
      case (bus.addr)
        asr_pkg::REG_CTRL:   s_d.ctrl   = bus.wdata;
        asr_pkg::REG_DIV_LO: s_d.div_lo = bus.wdata;
        asr_pkg::REG_DIV_HI: s_d.div_hi = bus.wdata;
        asr_pkg::REG_IRQ:    s_d.irqc   = bus.wdata;
        default:             ;
      endcase
    end

    s_d.irq_hi = req & s_q.irqc.rx_irq_priority;
    s_d.irq_lo = req & ~s_q.irqc.rx_irq_priority;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q        <= '0;
      s_q.sync   <= 3'b111;
      s_q.line   <= 1'b1;
      s_q.line_prev <= 1'b1;
      s_q.ctrl   <= asr_pkg::CTRL_RST;
      s_q.div_lo <= asr_pkg::DIV_RST;
      s_q.div_hi <= asr_pkg::DIV_RST;
      s_q.irqc   <= asr_pkg::IRQ_RST;
      s_q.st     <= asr_pkg::RX_IDLE;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign rdata            = s_q.rdata;
  assign irq_high         = s_q.irq_hi;
  assign irq_low          = s_q.irq_lo;
  assign rx_complete_flag = fifo_valid;

endmodule

// ---- test/asr_rx_asserts.sv ----
// Concurrent checks on the serial receiver's ports
`timescale 1ns/100ps
module asr_rx_chk #(
  parameter int DEPTH = 16
) (
  input wire logic              clk,             // System clock
  input wire logic              rst_n,           // Synchronous reset
  input wire logic              ce,              // Clock enable
  input wire logic              serial_in_pin,   // Receive line
  input wire asr_pkg::asr_bus_t bus,             // Register request
  input wire logic [7:0]        rdata,           // Read data
  input wire logic              irq_high,        // High priority request
  input wire logic              irq_low,         // Low priority request
  input wire logic              rx_complete_flag // Character buffered
);
  asr_pkg::asr_ctrl_t ctrl_q;
  asr_pkg::asr_irqc_t irqc_q;
  logic               req_w;
  // Shadows of the control registers, followed from bus writes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q <= '0;
      irqc_q <= '0;
    end else if (ce && bus.wr) begin
      if (bus.addr == asr_pkg::REG_CTRL) ctrl_q <= bus.wdata;
      if (bus.addr == asr_pkg::REG_IRQ) irqc_q <= bus.wdata;
    end
  end
  assign req_w = rx_complete_flag && irqc_q.rx_irq_enable && irqc_q.global_irq_enable
                 && irqc_q.peripheral_irq_enable;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence stat_rd_s;
    ce && bus.rd && bus.addr == asr_pkg::REG_STATUS;
  endsequence
  rdata_idle_a: assert property ($past(ce) && !$past(bus.rd) |-> rdata == 8'h00)
    else $error("read data not zero outside a read");
  rd_empty_a: assert property (ce && bus.rd && bus.addr == asr_pkg::REG_DATA && !rx_complete_flag |=> rdata == 8'h00)
    else $error("empty buffer read gave data");
  irq_hi_cause_a: assert property ($past(ce) && irq_high |-> $past(req_w && irqc_q.rx_irq_priority))
    else $error("high request without cause");
  irq_lo_cause_a: assert property ($past(ce) && irq_low |-> $past(req_w && !irqc_q.rx_irq_priority))
    else $error("low request without cause");
  irq_fire_a: assert property ($past(ce && req_w) |-> irq_high == $past(irqc_q.rx_irq_priority) && irq_low != irq_high)
    else $error("enabled request not raised");
  flag_hold_a: assert property (ce && rx_complete_flag && !(bus.rd && bus.addr == asr_pkg::REG_DATA) |=> rx_complete_flag)
    else $error("complete flag dropped without a data read");
  flag_gate_a: assert property ($rose(rx_complete_flag) |-> $past(ctrl_q.continuous_rx_enable
    && ctrl_q.serial_port_enable && !ctrl_q.clocked_mode_select))
    else $error("character taken while receiver off");
  stat_level_a: assert property (stat_rd_s |=> rdata[3] == $past(rx_complete_flag))
    else $error("status non-empty bit wrong");
  stat_ninth_a: assert property (stat_rd_s ##0 !ctrl_q.nine_bit_rx_enable |=> rdata[0] == 1'b0)
    else $error("ninth bit shown in eight-bit mode");
  ovr_clear_a: assert property (stat_rd_s ##0 !$past(ctrl_q.continuous_rx_enable) |=> rdata[2] == 1'b0)
    else $error("overrun kept after receive disable");
endmodule
bind asr_rx asr_rx_chk #(.DEPTH(DEPTH)) i_asr_rx_chk (.clk(clk), .rst_n(rst_n), .ce(ce),
  .serial_in_pin(serial_in_pin), .bus(bus), .rdata(rdata), .irq_high(irq_high), .irq_low(irq_low),
  .rx_complete_flag(rx_complete_flag));

// ---- test/asr_tx_model.sv ----
// Remote transmitter model driving the receive line
`timescale 1ns/100ps
module asr_tx_model (
  input  wire logic clk,  // System clock
  output logic      line  // Serial line, idle high
);
  initial line = 1'b1;
  // One frame: start, data LSB first, ninth bit if asked, stop, one idle bit
  task automatic send(input logic [8:0] d, input logic nine, input logic stop, input int clks);
    logic [10:0] fr;
    fr = nine ? {stop, d, 1'b0} : {1'b1, stop, d[7:0], 1'b0};
    @(posedge clk);
    for (int i = 0; i < (nine ? 11 : 10); i++) begin
      line <= fr[i];
      repeat (clks) @(posedge clk);
    end
    line <= 1'b1;
    repeat (clks) @(posedge clk);
  endtask
endmodule

// ---- test/tb_top.sv ----
// Self-checking bench for the serial receiver
`timescale 1ns/100ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_fail++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_top;
  logic              clk;
  logic              rst_n;
  logic              ce;
  logic              line;
  asr_pkg::asr_bus_t bus;
  logic [7:0]        rdata;
  logic              irq_high;
  logic              irq_low;
  logic              flag;
  logic [7:0]        v;
  int                n_fail;
  int                check_count;
  asr_rx #(.DEPTH(4)) i_asr_rx (.clk(clk), .rst_n(rst_n), .ce(ce), .serial_in_pin(line), .bus(bus),
    .rdata(rdata), .irq_high(irq_high), .irq_low(irq_low), .rx_complete_flag(flag));
  asr_tx_model i_asr_tx_model (.clk(clk), .line(line));
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic go(input logic [8:0] d, input logic nine, input logic stop);
    i_asr_tx_model.send(d, nine, stop, 16);
    #1;
  endtask
  task automatic t_regs();
    logic [2:0] ra[5] = '{asr_pkg::REG_CTRL, asr_pkg::REG_DIV_LO, asr_pkg::REG_DIV_HI, asr_pkg::REG_IRQ, 3'h6};
    foreach (ra[i]) begin
      rd(ra[i]);
      `CHK(v, 8'h00)
    end
    wr(asr_pkg::REG_DIV_HI, 8'h5a);
    rd(asr_pkg::REG_DIV_HI);
    `CHK(v, 8'h5a)
  endtask
  task automatic t_rate();
    logic [23:0] m[4] = '{24'h090001, 24'h290300, 24'h490301, 24'h690f00};
    for (int i = 0; i < 4; i++) begin
      wr(asr_pkg::REG_DIV_LO, m[i][15:8]);
      wr(asr_pkg::REG_DIV_HI, m[i][7:0]);
      wr(asr_pkg::REG_CTRL, m[i][23:16]);
      i_asr_tx_model.send({1'b0, 8'hc0 + 8'(i)}, 1'b0, 1'b1, 64);
      #1;
      rd(asr_pkg::REG_DATA);
      `CHK(v, 8'hc0 + 8'(i))
    end
  endtask
  task automatic t_off();
    wr(asr_pkg::REG_DIV_LO, 8'h03);
    wr(asr_pkg::REG_CTRL, 8'h61);
    go(9'h0a5, 1'b0, 1'b1);
    `CHK(flag, 1'b0)
    wr(asr_pkg::REG_CTRL, 8'h6b);
    go(9'h0a5, 1'b0, 1'b1);
    `CHK(flag, 1'b0)
  endtask
  task automatic t_filter();
    wr(asr_pkg::REG_CTRL, 8'h6d);
    wr(asr_pkg::REG_CTRL, 8'h7d);
    go(9'h011, 1'b1, 1'b1);
    `CHK(flag, 1'b0)
    go(9'h142, 1'b1, 1'b1);
    `CHK(flag, 1'b1)
    rd(asr_pkg::REG_STATUS);
    `CHK(v[1:0], 2'b01)
    rd(asr_pkg::REG_DATA);
    `CHK(v, 8'h42)
    wr(asr_pkg::REG_CTRL, 8'h6d);
    go(9'h033, 1'b1, 1'b1);
    rd(asr_pkg::REG_STATUS);
    `CHK(v[3:0], 4'h8)
    rd(asr_pkg::REG_DATA);
    `CHK(v, 8'h33)
  endtask
  task automatic t_ferr();
    wr(asr_pkg::REG_CTRL, 8'h69);
    go(9'h05c, 1'b0, 1'b0);
    rd(asr_pkg::REG_STATUS);
    `CHK(v[1], 1'b1)
    rd(asr_pkg::REG_DATA);
    `CHK(v, 8'h5c)
    `CHK(flag, 1'b0)
  endtask
  task automatic t_irq();
    logic [9:0] it[4] = '{{8'h01, 2'b00}, {8'h83, 2'b00}, {8'hc1, 2'b01}, {8'hc3, 2'b10}};
    go(9'h077, 1'b0, 1'b1);
    foreach (it[i]) begin
      wr(asr_pkg::REG_IRQ, it[i][9:2]);
      repeat (2) @(posedge clk);
      `CHK({irq_high, irq_low}, it[i][1:0])
    end
    rd(asr_pkg::REG_DATA);
    repeat (2) @(posedge clk);
    `CHK({irq_high, irq_low}, 2'b00)
  endtask
  task automatic t_ovr();
    for (int i = 0; i < 5; i++) go({1'b0, 8'h10 + 8'(i)}, 1'b0, 1'b1);
    rd(asr_pkg::REG_STATUS);
    `CHK(v[3:2], 2'b11)
    wr(asr_pkg::REG_CTRL, 8'h61);
    rd(asr_pkg::REG_STATUS);
    `CHK(v[2], 1'b0)
    for (int i = 0; i < 4; i++) begin
      rd(asr_pkg::REG_DATA);
      `CHK(v, 8'h10 + 8'(i))
    end
    `CHK(flag, 1'b0)
  endtask
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    bus = '0;
    n_fail = 0;
    check_count = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_rate();
    t_off();
    t_filter();
    t_ferr();
    t_irq();
    t_ovr();
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    give_verdict();
  end
endmodule
